//--- hw/clock_gate_ctrl.sv
// Purpose: Peripheral clock gates, unique identifier and bus clock divider behind APB
// Assumes: Single clock pclk at 20 MHz; gated clocks leave as one-cycle enables
// Notes:   Divider select survives presetn and is reset to 1 (half rate) only by power_on_resetn
// How it works
// - Gate bit 19 stops the second serial-peripheral clock at 0, passes at 1.
// - Gate bit 18 controls the first serial-peripheral clock.
// - Gate bit 17 controls the two-wire bus controller clock.
// - Reserved bits of the gate and divider registers read zero, ignore writes.
// - Gate bit 13 controls the serial-wire debug clock.
// - Gate bit 12 controls the flash clock.
// - Gate bit 10 controls the CRC unit clock.
// - Gate bit 7 controls the third flexible timer clock.
// - Gate bit 6 controls the second flexible timer clock.
// - Gate bit 5 controls the first flexible timer clock.
// - Gate bit 1 controls the periodic interrupt timer clock.
// - Gate bit 0 controls the real-time clock module clock.
// - Offset 0x10 reads the low identifier word, read-only.
// - Offset 0x14 reads the high identifier word, read-only.
// - Divider bit 0 gives full-rate bus clock, 1 gives half rate.
// - Ordinary reset leaves the divider bit unchanged.
// - The gate register sits at offset 0x0C.
`timescale 1ns/1ps
`default_nettype none

module clock_gate_ctrl
    import clock_gate_pkg::*;
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        power_on_resetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    input  wire logic [3:0]  pstrb,
    output logic             pready,
    output logic [31:0]      prdata,
    output logic             pslverr,
    input  wire logic [31:0] identifier_low_bits,
    input  wire logic [31:0] identifier_high_bits,
    output logic             bus_clock_enable,
    output logic             serial_peripheral_second_clock_enable,
    output logic             serial_peripheral_first_clock_enable,
    output logic             two_wire_clock_enable,
    output logic             debug_wire_clock_enable,
    output logic             flash_clock_enable,
    output logic             crc_clock_enable,
    output logic             flex_timer_third_clock_enable,
    output logic             flex_timer_second_clock_enable,
    output logic             flex_timer_first_clock_enable,
    output logic             periodic_interrupt_timer_clock_enable,
    output logic             real_time_clock_clock_enable
);

    // ****************************************
    // Helpers
    // ****************************************

    // Byte-lane merge of a write into a register under a writable mask
    function automatic logic [31:0] merge_write(input logic [31:0] old_value,
                                                input logic [31:0] data,
                                                input logic [3:0]  strobe,
                                                input logic [31:0] mask);
        logic [31:0] lanes;
        lanes = {{8{strobe[3]}}, {8{strobe[2]}}, {8{strobe[1]}}, {8{strobe[0]}}};
        return (old_value & ~(lanes & mask)) | (data & lanes & mask);
    endfunction

    // Address decode for the read path's error flag; writes compare paddr directly
    function automatic logic is_mapped(input logic [7:0] addr);
        return (addr == OFFSET_GATES) || (addr == OFFSET_ID_LOW) ||
               (addr == OFFSET_ID_HIGH) || (addr == OFFSET_BUS_DIVIDE);
    endfunction

    // ****************************************
    // State
    // ****************************************
    logic [31:0] gates_reg;
    logic        divide_select_reg;
    logic        phase_reg;
    logic        bus_tick_next;
    logic        setup_phase;
    logic        write_strobe;

    assign setup_phase  = psel && !penable;
    assign write_strobe = psel && penable && pwrite;
    assign pready       = 1'b1;

    // ****************************************
    // Register writes
    // ****************************************

    // Gate register; reserved bits never stored
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            gates_reg <= GATES_RESET;
        end else if (write_strobe && paddr == OFFSET_GATES) begin
            gates_reg <= merge_write(gates_reg, pwdata, pstrb, GATES_WRITE_MASK);
        end
    end

    // Divider select; reset to 1 only by power-on reset
    always_ff @(posedge pclk or negedge power_on_resetn) begin
        if (!power_on_resetn) begin
            divide_select_reg <= DIVIDE_POWER_ON;
        end else if (write_strobe && paddr == OFFSET_BUS_DIVIDE && pstrb[0]) begin
            divide_select_reg <= pwdata[BIT_BUS_DIVIDE_SELECT];
        end
    end

    // ****************************************
    // Read path
    // ****************************************

    // Read data and error captured in the setup cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else if (setup_phase) begin
            pslverr <= !is_mapped(paddr);
            unique case (paddr)
                OFFSET_GATES:      prdata <= gates_reg & GATES_WRITE_MASK;
                OFFSET_ID_LOW:     prdata <= identifier_low_bits;
                OFFSET_ID_HIGH:    prdata <= identifier_high_bits;
                OFFSET_BUS_DIVIDE: prdata <= {31'h0, divide_select_reg};
                default:           prdata <= 32'h0000_0000;
            endcase
        end
    end

    // ****************************************
    // Bus clock divider
    // ****************************************

    // Tick every cycle, or every other cycle when halved
    assign bus_tick_next = divide_select_reg ? !phase_reg : 1'b1;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            phase_reg <= 1'b0;
        end else begin
            phase_reg <= divide_select_reg ? !phase_reg : 1'b0;
        end
    end

    // ****************************************
    // Peripheral gates
    // ****************************************

    // Enables registered together so a gate change lands on a whole tick
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bus_clock_enable                      <= 1'b0;
            serial_peripheral_second_clock_enable <= 1'b0;
            serial_peripheral_first_clock_enable  <= 1'b0;
            two_wire_clock_enable                 <= 1'b0;
            debug_wire_clock_enable               <= 1'b0;
            flash_clock_enable                    <= 1'b0;
            crc_clock_enable                      <= 1'b0;
            flex_timer_third_clock_enable         <= 1'b0;
            flex_timer_second_clock_enable        <= 1'b0;
            flex_timer_first_clock_enable         <= 1'b0;
            periodic_interrupt_timer_clock_enable <= 1'b0;
            real_time_clock_clock_enable          <= 1'b0;
        end else begin
            bus_clock_enable                      <= bus_tick_next;
            serial_peripheral_second_clock_enable <= bus_tick_next && gates_reg[BIT_SERIAL_PERIPHERAL_SECOND];
            serial_peripheral_first_clock_enable  <= bus_tick_next && gates_reg[BIT_SERIAL_PERIPHERAL_FIRST];
            two_wire_clock_enable                 <= bus_tick_next && gates_reg[BIT_TWO_WIRE];
            debug_wire_clock_enable               <= bus_tick_next && gates_reg[BIT_DEBUG_WIRE];
            flash_clock_enable                    <= bus_tick_next && gates_reg[BIT_FLASH];
            crc_clock_enable                      <= bus_tick_next && gates_reg[BIT_CRC];
            flex_timer_third_clock_enable         <= bus_tick_next && gates_reg[BIT_FLEX_TIMER_THIRD];
            flex_timer_second_clock_enable        <= bus_tick_next && gates_reg[BIT_FLEX_TIMER_SECOND];
            flex_timer_first_clock_enable         <= bus_tick_next && gates_reg[BIT_FLEX_TIMER_FIRST];
            periodic_interrupt_timer_clock_enable <= bus_tick_next && gates_reg[BIT_PERIODIC_TIMER];
            real_time_clock_clock_enable          <= bus_tick_next && gates_reg[BIT_REAL_TIME_CLOCK];
        end
    end

    // ****************************************
    // Checks
    // ****************************************

    // Second serial-peripheral enable follows bit and tick one cycle later
    AST_SERIAL_SECOND_GATE: assert property (@(posedge pclk) disable iff (!presetn)
        serial_peripheral_second_clock_enable ==
            ($past(bus_tick_next) && $past(gates_reg[BIT_SERIAL_PERIPHERAL_SECOND])))
        else $error("second serial peripheral enable wrong");

    AST_SERIAL_FIRST_BLOCKED: assert property (@(posedge pclk) disable iff (!presetn)
        !gates_reg[BIT_SERIAL_PERIPHERAL_FIRST] ##1 !gates_reg[BIT_SERIAL_PERIPHERAL_FIRST]
        |-> !serial_peripheral_first_clock_enable)
        else $error("first serial peripheral clocked while gated");

    AST_TWO_WIRE_PASS: assert property (@(posedge pclk) disable iff (!presetn)
        (gates_reg[BIT_TWO_WIRE] && bus_tick_next) |=> two_wire_clock_enable)
        else $error("two-wire clock not passed");

    AST_RESERVED_ZERO: assert property (@(posedge pclk) disable iff (!presetn)
        (gates_reg & ~GATES_WRITE_MASK) == 32'h0000_0000)
        else $error("reserved gate bits set");

    AST_DIVIDER_READ: assert property (@(posedge pclk) disable iff (!presetn)
        (setup_phase && paddr == OFFSET_BUS_DIVIDE) |=> prdata[31:1] == 31'h0)
        else $error("divider reserved bits nonzero");

    AST_FLASH_SLAVE: assert property (@(posedge pclk) disable iff (!presetn)
        flash_clock_enable |-> bus_clock_enable)
        else $error("flash enable without bus tick");

    AST_ID_LOW_READ: assert property (@(posedge pclk) disable iff (!presetn)
        (setup_phase && paddr == OFFSET_ID_LOW) |=> prdata == $past(identifier_low_bits))
        else $error("low identifier read wrong");

    AST_ID_HIGH_READ: assert property (@(posedge pclk) disable iff (!presetn)
        (setup_phase && paddr == OFFSET_ID_HIGH) |=> prdata == $past(identifier_high_bits))
        else $error("high identifier read wrong");

    AST_HALF_RATE: assert property (@(posedge pclk) disable iff (!presetn)
        ($past(divide_select_reg) && divide_select_reg && bus_clock_enable) ##1 divide_select_reg
        |-> !bus_clock_enable)
        else $error("halved bus clock ticked twice in a row");

    AST_FULL_RATE: assert property (@(posedge pclk) disable iff (!presetn)
        !divide_select_reg |=> bus_clock_enable)
        else $error("full-rate bus clock missed a tick");

    AST_GATES_WRITE: assert property (@(posedge pclk) disable iff (!presetn)
        (write_strobe && paddr == OFFSET_GATES && pstrb == 4'hF)
        |=> gates_reg == ($past(pwdata) & GATES_WRITE_MASK))
        else $error("gate register write lost");

    AST_UNMAPPED_ERR: assert property (@(posedge pclk) disable iff (!presetn)
        (setup_phase && !is_mapped(paddr)) |=> pslverr)
        else $error("unmapped access not flagged");

    // ****************************************
    // Per-gate and divider checks
    // ****************************************

    // First serial peripheral passes on a tick
    AST_SERIAL_FIRST_PASS: assert property (@(posedge pclk) disable iff (!presetn)
        (gates_reg[BIT_SERIAL_PERIPHERAL_FIRST] && bus_tick_next) |=> serial_peripheral_first_clock_enable)
        else $error("first serial peripheral clock not passed");

    // Two-wire held off while gated
    AST_TWO_WIRE_BLOCKED: assert property (@(posedge pclk) disable iff (!presetn)
        !gates_reg[BIT_TWO_WIRE] |=> !two_wire_clock_enable)
        else $error("two-wire clocked while gated");

    // Debug wire passes on a tick
    AST_DEBUG_WIRE_PASS: assert property (@(posedge pclk) disable iff (!presetn)
        (gates_reg[BIT_DEBUG_WIRE] && bus_tick_next) |=> debug_wire_clock_enable)
        else $error("debug-wire clock not passed");

    // Debug wire held off while gated
    AST_DEBUG_WIRE_BLOCKED: assert property (@(posedge pclk) disable iff (!presetn)
        !gates_reg[BIT_DEBUG_WIRE] |=> !debug_wire_clock_enable)
        else $error("debug-wire clocked while gated");

    // Flash passes on a tick
    AST_FLASH_PASS: assert property (@(posedge pclk) disable iff (!presetn)
        (gates_reg[BIT_FLASH] && bus_tick_next) |=> flash_clock_enable)
        else $error("flash clock not passed");

    // Flash held off while gated
    AST_FLASH_BLOCKED: assert property (@(posedge pclk) disable iff (!presetn)
        !gates_reg[BIT_FLASH] |=> !flash_clock_enable)
        else $error("flash clocked while gated");

    // CRC unit passes on a tick
    AST_CRC_PASS: assert property (@(posedge pclk) disable iff (!presetn)
        (gates_reg[BIT_CRC] && bus_tick_next) |=> crc_clock_enable)
        else $error("CRC clock not passed");

    // CRC unit held off while gated
    AST_CRC_BLOCKED: assert property (@(posedge pclk) disable iff (!presetn)
        !gates_reg[BIT_CRC] |=> !crc_clock_enable)
        else $error("CRC clocked while gated");

    // Third flexible timer passes on a tick
    AST_TIMER_THIRD_PASS: assert property (@(posedge pclk) disable iff (!presetn)
        (gates_reg[BIT_FLEX_TIMER_THIRD] && bus_tick_next) |=> flex_timer_third_clock_enable)
        else $error("third timer clock not passed");

    // Third flexible timer held off while gated
    AST_TIMER_THIRD_BLOCKED: assert property (@(posedge pclk) disable iff (!presetn)
        !gates_reg[BIT_FLEX_TIMER_THIRD] |=> !flex_timer_third_clock_enable)
        else $error("third timer clocked while gated");

    // Second flexible timer passes on a tick
    AST_TIMER_SECOND_PASS: assert property (@(posedge pclk) disable iff (!presetn)
        (gates_reg[BIT_FLEX_TIMER_SECOND] && bus_tick_next) |=> flex_timer_second_clock_enable)
        else $error("second timer clock not passed");

    // Second flexible timer held off while gated
    AST_TIMER_SECOND_BLOCKED: assert property (@(posedge pclk) disable iff (!presetn)
        !gates_reg[BIT_FLEX_TIMER_SECOND] |=> !flex_timer_second_clock_enable)
        else $error("second timer clocked while gated");

    // First flexible timer passes on a tick
    AST_TIMER_FIRST_PASS: assert property (@(posedge pclk) disable iff (!presetn)
        (gates_reg[BIT_FLEX_TIMER_FIRST] && bus_tick_next) |=> flex_timer_first_clock_enable)
        else $error("first timer clock not passed");

    // First flexible timer held off while gated
    AST_TIMER_FIRST_BLOCKED: assert property (@(posedge pclk) disable iff (!presetn)
        !gates_reg[BIT_FLEX_TIMER_FIRST] |=> !flex_timer_first_clock_enable)
        else $error("first timer clocked while gated");

    // Periodic timer passes on a tick
    AST_PERIODIC_TIMER_PASS: assert property (@(posedge pclk) disable iff (!presetn)
        (gates_reg[BIT_PERIODIC_TIMER] && bus_tick_next) |=> periodic_interrupt_timer_clock_enable)
        else $error("periodic timer clock not passed");

    // Periodic timer held off while gated
    AST_PERIODIC_TIMER_BLOCKED: assert property (@(posedge pclk) disable iff (!presetn)
        !gates_reg[BIT_PERIODIC_TIMER] |=> !periodic_interrupt_timer_clock_enable)
        else $error("periodic timer clocked while gated");

    // Real-time clock passes on a tick
    AST_REAL_TIME_PASS: assert property (@(posedge pclk) disable iff (!presetn)
        (gates_reg[BIT_REAL_TIME_CLOCK] && bus_tick_next) |=> real_time_clock_clock_enable)
        else $error("real-time clock not passed");

    // Real-time clock held off while gated
    AST_REAL_TIME_BLOCKED: assert property (@(posedge pclk) disable iff (!presetn)
        !gates_reg[BIT_REAL_TIME_CLOCK] |=> !real_time_clock_clock_enable)
        else $error("real-time clocked while gated");

    // No gated enable other than flash outside a bus tick
    AST_GATES_ON_TICK: assert property (@(posedge pclk) disable iff (!presetn)
        (serial_peripheral_second_clock_enable || serial_peripheral_first_clock_enable ||
         two_wire_clock_enable || debug_wire_clock_enable || crc_clock_enable ||
         flex_timer_third_clock_enable || flex_timer_second_clock_enable ||
         flex_timer_first_clock_enable || periodic_interrupt_timer_clock_enable ||
         real_time_clock_clock_enable) |-> bus_clock_enable)
        else $error("gated clock ticked off the bus tick");

    // Divider select survives the ordinary reset
    AST_DIVIDE_KEPT: assert property (@(posedge pclk) disable iff (!power_on_resetn)
        (presetn && !write_strobe) ##1 !presetn
        |-> divide_select_reg == $past(divide_select_reg))
        else $error("divider select lost in reset");

    // Divider write lands
    AST_DIVIDE_WRITE: assert property (@(posedge pclk) disable iff (!power_on_resetn)
        (write_strobe && paddr == OFFSET_BUS_DIVIDE && pstrb[0])
        |=> divide_select_reg == $past(pwdata[BIT_BUS_DIVIDE_SELECT]))
        else $error("divider write lost");

    // Divider bit read back
    AST_DIVIDER_READ_BIT: assert property (@(posedge pclk) disable iff (!presetn)
        (setup_phase && paddr == OFFSET_BUS_DIVIDE) |=> prdata[0] == $past(divide_select_reg))
        else $error("divider bit read wrong");

    // Gate register read back
    AST_GATES_READ: assert property (@(posedge pclk) disable iff (!presetn)
        (setup_phase && paddr == OFFSET_GATES) |=> prdata == $past(gates_reg))
        else $error("gate register read wrong");

    COV_HALF_RATE: cover property (@(posedge pclk) disable iff (!presetn)
        divide_select_reg && bus_clock_enable ##1 !bus_clock_enable);
    COV_GATE_ON: cover property (@(posedge pclk) disable iff (!presetn)
        !gates_reg[BIT_CRC] ##1 gates_reg[BIT_CRC] ##[1:2] crc_clock_enable);
    COV_ID_READ: cover property (@(posedge pclk) disable iff (!presetn)
        setup_phase && paddr == OFFSET_ID_HIGH);
    COV_UNMAPPED: cover property (@(posedge pclk) disable iff (!presetn)
        psel && penable && pslverr);
    COV_RESET_KEEPS_DIVIDER: cover property (@(posedge pclk)
        !presetn ##1 presetn && !divide_select_reg);

endmodule

`default_nettype wire

//--- inc/clock_gate_pkg.sv
// Purpose: Shared constants for the peripheral clock gating and bus divider
// Assumes: APB slave with 32-bit data; one word per register
// Notes:   Offsets are byte addresses
package clock_gate_pkg;

    // ****************************************
    // Register offsets
    // ****************************************
    localparam logic [7:0] OFFSET_GATES      = 8'h0C;
    localparam logic [7:0] OFFSET_ID_LOW     = 8'h10;
    localparam logic [7:0] OFFSET_ID_HIGH    = 8'h14;
    localparam logic [7:0] OFFSET_BUS_DIVIDE = 8'h18;

    // ****************************************
    // Gate bit positions
    // ****************************************
    localparam int BIT_SERIAL_PERIPHERAL_SECOND = 19;
    localparam int BIT_SERIAL_PERIPHERAL_FIRST  = 18;
    localparam int BIT_TWO_WIRE                 = 17;
    localparam int BIT_DEBUG_WIRE               = 13;
    localparam int BIT_FLASH                    = 12;
    localparam int BIT_CRC                      = 10;
    localparam int BIT_FLEX_TIMER_THIRD         = 7;
    localparam int BIT_FLEX_TIMER_SECOND        = 6;
    localparam int BIT_FLEX_TIMER_FIRST         = 5;
    localparam int BIT_PERIODIC_TIMER           = 1;
    localparam int BIT_REAL_TIME_CLOCK          = 0;
    localparam int BIT_BUS_DIVIDE_SELECT        = 0;

    // ****************************************
    // Writable masks and reset values
    // ****************************************
    localparam logic [31:0] GATES_WRITE_MASK  = 32'h000E_34E3;
    localparam logic [31:0] DIVIDE_WRITE_MASK = 32'h0000_0001;
    localparam logic [31:0] GATES_RESET       = 32'h0000_3000;
    localparam logic        DIVIDE_POWER_ON   = 1'b1;

    // ****************************************
    // Clock figures
    // ****************************************
    localparam int PCLK_HZ = 20_000_000;

endpackage

//--- sim/peripheral_clock_gating_and_bus_divider_tb.sv
// Purpose: Self-checking bench for the clock gates, identifier words and bus divider
// Assumes: APB slave answers when pready is high; enables are registered pulses
// Notes:   Inputs driven by non-blocking assignment right after rising edges
`timescale 1ns/1ps
`default_nettype none

module peripheral_clock_gating_and_bus_divider_tb
    import clock_gate_pkg::*;
;
    // ****************************************
    // Stimulus and observation signals
    // ****************************************
    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic        power_on_resetn = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [3:0]  pstrb = 4'hF;
    logic        pready;
    logic [31:0] prdata;
    logic        pslverr;
    logic [31:0] id_low = 32'hA5C3_1E70;
    logic [31:0] id_high = 32'h5A3C_E18F;
    logic        bus_clock_enable;
    logic [31:0] en_vec;
    logic [10:0] en_raw;
    int          n_mismatch = 0;
    int          checks_done = 0;
    int          bits[11] = '{19, 18, 17, 13, 12, 10, 7, 6, 5, 1, 0};

    // Clock of 50 ns period
    always #25 pclk = ~pclk;

    clock_gate_ctrl i_clock_gate_ctrl (
        .pclk                                  (pclk),
        .presetn                               (presetn),
        .power_on_resetn                       (power_on_resetn),
        .psel                                  (psel),
        .penable                               (penable),
        .pwrite                                (pwrite),
        .paddr                                 (paddr),
        .pwdata                                (pwdata),
        .pstrb                                 (pstrb),
        .pready                                (pready),
        .prdata                                (prdata),
        .pslverr                               (pslverr),
        .identifier_low_bits                   (id_low),
        .identifier_high_bits                  (id_high),
        .bus_clock_enable                      (bus_clock_enable),
        .serial_peripheral_second_clock_enable (en_raw[10]),
        .serial_peripheral_first_clock_enable  (en_raw[9]),
        .two_wire_clock_enable                 (en_raw[8]),
        .debug_wire_clock_enable               (en_raw[7]),
        .flash_clock_enable                    (en_raw[6]),
        .crc_clock_enable                      (en_raw[5]),
        .flex_timer_third_clock_enable         (en_raw[4]),
        .flex_timer_second_clock_enable        (en_raw[3]),
        .flex_timer_first_clock_enable         (en_raw[2]),
        .periodic_interrupt_timer_clock_enable (en_raw[1]),
        .real_time_clock_clock_enable          (en_raw[0])
    );
    // Place each enable at its gate bit position
    always_comb begin
        en_vec = 32'h0000_0000;
        for (int k = 0; k < 11; k++) begin
            en_vec[bits[k]] = en_raw[10 - k];
        end
    end

    // ****************************************
    // Helper tasks
    // ****************************************
    task automatic close_out();
        if (n_mismatch == 0 && checks_done > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // One APB transfer, then one idle cycle
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] r, output logic e);
        int n;
        n = 0;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1) begin
            n_mismatch++;
            close_out();
        end
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input logic exp_err);
        logic [31:0] r;
        logic        e;
        apb(1'b0, a, 32'h0000_0000, r, e);
        check("read data", r, exp);
        check("error flag", {31'h0, e}, {31'h0, exp_err});
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic        e;
        apb(1'b1, a, d, r, e);
    endtask

    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        int ticks;
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        power_on_resetn <= 1'b1;
        @(posedge pclk);
        rd_chk(8'h0C, 32'h0000_3000, 1'b0);
        rd_chk(8'h18, 32'h0000_0001, 1'b0);
        rd_chk(8'h10, id_low, 1'b0);
        rd_chk(8'h14, id_high, 1'b0);
        wr(8'h10, 32'hFFFF_FFFF);
        wr(8'h14, 32'h0000_0000);
        rd_chk(8'h10, id_low, 1'b0);
        rd_chk(8'h14, id_high, 1'b0);
        rd_chk(8'h20, 32'h0000_0000, 1'b1);
        wr(8'h0C, 32'hFFFF_FFFF);
        rd_chk(8'h0C, 32'h000E_34E3, 1'b0);
        wr(8'h18, 32'hFFFF_FFFF);
        rd_chk(8'h18, 32'h0000_0001, 1'b0);
        pstrb <= 4'hE;
        wr(8'h18, 32'h0000_0000);
        pstrb <= 4'hF;
        rd_chk(8'h18, 32'h0000_0001, 1'b0);
        wr(8'h18, 32'h0000_0000);
        // Each gate alone at full bus rate
        for (int k = 0; k < 11; k++) begin
            wr(8'h0C, 32'h1 << bits[k]);
            repeat (2) @(posedge pclk);
            repeat (4) begin
                @(posedge pclk);
                check("gate enables", en_vec, 32'h1 << bits[k]);
                check("bus tick", {31'h0, bus_clock_enable}, 32'h1);
            end
        end
        // Half rate: all gates on, half the edges carry a tick
        wr(8'h0C, 32'hFFFF_FFFF);
        wr(8'h18, 32'h0000_0001);
        repeat (2) @(posedge pclk);
        ticks = 0;
        repeat (8) begin
            @(posedge pclk);
            if (bus_clock_enable === 1'b1) ticks++;
            check("gates at half rate", en_vec, bus_clock_enable === 1'b1 ? 32'h000E_34E3 : 32'h0);
        end
        check("ticks in 8 cycles", ticks, 32'd4);
        // Ordinary reset keeps the divider select
        wr(8'h18, 32'h0000_0000);
        presetn <= 1'b0;
        repeat (3) begin
            @(posedge pclk);
            check("enables in reset", en_vec, 32'h0);
        end
        presetn <= 1'b1;
        @(posedge pclk);
        rd_chk(8'h18, 32'h0000_0000, 1'b0);
        rd_chk(8'h0C, 32'h0000_3000, 1'b0);
        power_on_resetn <= 1'b0;
        repeat (2) @(posedge pclk);
        power_on_resetn <= 1'b1;
        @(posedge pclk);
        rd_chk(8'h18, 32'h0000_0001, 1'b0);
        close_out();
    end
endmodule

`default_nettype wire
